// ===== hdl/srrs_top.sv
// srrs_top.sv: stop release and reset sequencer
// assumes: reset sources and interrupt flags are synchronous to CLOCK_I
`include "srrs_map.svh"
`default_nettype none
module srrs_top #(
  parameter bit LONG_SETTLE = 1'b0,
  parameter logic [15:0] RESET_VECTOR = 16'h0100,
  parameter int unsigned SETTLE_BITS = `SRRS_SETTLE_BITS
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // reset sources
  input wire logic RESET_N_I,
  input wire logic WDT_OVF_I,
  input wire logic SUPPLY_LOW_I,
  // stop entry and interrupt state
  input wire logic STOP_REQ_I,
  input wire logic IRQ_PENDING_I,
  input wire logic INTERRUPT_MASK_FLAG_I,
  input wire logic INTERRUPT_ACCEPT_FLAG_I,
  // cpu control
  output var srrs_pkg::srrs_cpu_t CPU_O,
  output logic OSC_RUN_O,
  output logic HALT_O,
  output logic STOPPED_O,
  // pins and ram
  output logic PINS_HIZ_O,
  output logic RAM_HOLD_O,
  // post-reset register image
  output var srrs_pkg::srrs_regs_t REGS_O
);
  srrs_pkg::srrs_state_t state_q;
  srrs_pkg::srrs_state_t state_d;
  srrs_pkg::srrs_after_t after_q;
  srrs_pkg::srrs_after_t after_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic pc_load_q;
  logic start_irq_q;
  logic start_next_q;
  logic standby_q;
  logic supply_seen_q;
  logic any_reset;
  logic wake_irq;
  logic settle_start;
  logic settle_done;
  logic settle_busy;
  logic rom_addr;
  logic [7:0] rom_data;

  // ==========================================================
  // reset merge
  // the pin must stay low for the documented minimum; this block does not
  // filter short pulses and simply treats every low sample as a reset
  assign any_reset = !RESET_N_I || WDT_OVF_I || SUPPLY_LOW_I;

  // an unmasked request wakes stop; a masked one leaves stop held
  assign wake_irq = IRQ_PENDING_I && !INTERRUPT_MASK_FLAG_I;

  // ==========================================================
  // settle counter and vector store
  assign settle_start = (state_q == srrs_pkg::SRRS_RESET && !any_reset) ||
                        (state_q == srrs_pkg::SRRS_STOP && wake_irq) ||
                        (state_q == srrs_pkg::SRRS_RUN && STOP_REQ_I && wake_irq &&
                         after_q != srrs_pkg::SRRS_GO_RESET);

  srrs_settle_cnt #(
    .BITS(SETTLE_BITS)
  ) u_settle (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .start_i(settle_start),
    .long_i(LONG_SETTLE),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );

  // low byte is addressed in vec_lo, high byte in vec_hi, each lands a cycle later
  assign rom_addr = (state_q == srrs_pkg::SRRS_VEC_HI);

  srrs_vec_rom #(
    .VECTOR(RESET_VECTOR)
  ) u_vec (
    .clk_i(CLOCK_I),
    .addr_i(rom_addr),
    .data_o(rom_data)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    after_d = after_q;
    if (any_reset) begin
      state_d = srrs_pkg::SRRS_RESET;
      after_d = srrs_pkg::SRRS_GO_RESET;
    end else begin
      case (state_q)
        srrs_pkg::SRRS_RESET: begin
          // pin, watchdog and supply release all end here alike
          state_d = srrs_pkg::SRRS_SETTLE;
        end
        srrs_pkg::SRRS_SETTLE: begin
          if (settle_done) begin
            state_d = srrs_pkg::SRRS_VEC_LO;
          end
        end
        srrs_pkg::SRRS_VEC_LO: begin
          state_d = srrs_pkg::SRRS_VEC_HI;
        end
        srrs_pkg::SRRS_VEC_HI: begin
          state_d = srrs_pkg::SRRS_RUN;
        end
        srrs_pkg::SRRS_RUN: begin
          if (after_q == srrs_pkg::SRRS_GO_RESET) begin
            // first run cycle takes the high vector byte; stop waits for it
            after_d = srrs_pkg::SRRS_GO_NEXT;
          end else if (STOP_REQ_I && wake_irq) begin
            // pending request: fall straight into halt-like wait
            state_d = srrs_pkg::SRRS_WAKE;
            after_d = INTERRUPT_ACCEPT_FLAG_I ? srrs_pkg::SRRS_GO_IRQ
                                              : srrs_pkg::SRRS_GO_NEXT;
          end else if (STOP_REQ_I) begin
            state_d = srrs_pkg::SRRS_STOP;
          end
        end
        srrs_pkg::SRRS_STOP: begin
          if (wake_irq) begin
            state_d = srrs_pkg::SRRS_WAKE;
            after_d = INTERRUPT_ACCEPT_FLAG_I ? srrs_pkg::SRRS_GO_IRQ
                                              : srrs_pkg::SRRS_GO_NEXT;
          end
        end
        srrs_pkg::SRRS_WAKE: begin
          if (settle_done) begin
            state_d = srrs_pkg::SRRS_RUN;
          end
        end
        default: begin
          state_d = srrs_pkg::SRRS_RESET;
        end
      endcase
    end
  end

  // vector bytes arrive one cycle after each address is presented
  assign pc_d = (state_q == srrs_pkg::SRRS_VEC_HI) ? {pc_q[15:8], rom_data} :
                (state_q == srrs_pkg::SRRS_RUN && after_q == srrs_pkg::SRRS_GO_RESET) ?
                {rom_data, pc_q[7:0]} : pc_q;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_q <= srrs_pkg::SRRS_RESET;
      after_q <= srrs_pkg::SRRS_GO_RESET;
      pc_q <= 16'h0000;
      pc_load_q <= 1'b0;
      start_irq_q <= 1'b0;
      start_next_q <= 1'b0;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      pc_q <= pc_d;
      pc_load_q <= (state_q == srrs_pkg::SRRS_RUN) && (after_q == srrs_pkg::SRRS_GO_RESET) &&
                   !pc_load_q;
      start_irq_q <= (state_q == srrs_pkg::SRRS_WAKE) && settle_done &&
                     (after_q == srrs_pkg::SRRS_GO_IRQ);
      start_next_q <= (state_q == srrs_pkg::SRRS_WAKE) && settle_done &&
                      (after_q == srrs_pkg::SRRS_GO_NEXT);
    end
  end

  // ==========================================================
  // standby memory and supply clear status
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      standby_q <= 1'b0;
      supply_seen_q <= 1'b0;
    end else begin
      if (state_q == srrs_pkg::SRRS_STOP || state_q == srrs_pkg::SRRS_WAKE) begin
        standby_q <= 1'b1;
      end else if (state_q == srrs_pkg::SRRS_RUN) begin
        standby_q <= 1'b0;
      end
      // supply source wins over any other cause seen in the same reset
      if (SUPPLY_LOW_I) begin
        supply_seen_q <= 1'b1;
      end else if (any_reset && state_q != srrs_pkg::SRRS_RESET) begin
        supply_seen_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outputs
  logic in_reset_seq;
  logic cpu_run;
  assign in_reset_seq = (state_q == srrs_pkg::SRRS_RESET) ||
                        (state_q == srrs_pkg::SRRS_SETTLE) ||
                        (state_q == srrs_pkg::SRRS_VEC_LO) ||
                        (state_q == srrs_pkg::SRRS_VEC_HI);

  assign PINS_HIZ_O = in_reset_seq || any_reset;
  assign RAM_HOLD_O = standby_q;
  assign STOPPED_O = (state_q == srrs_pkg::SRRS_STOP);
  assign HALT_O = (state_q == srrs_pkg::SRRS_WAKE);
  assign OSC_RUN_O = (state_q != srrs_pkg::SRRS_STOP) || settle_busy;
  assign cpu_run = (state_q == srrs_pkg::SRRS_RUN) && !pc_load_q &&
                   (after_q != srrs_pkg::SRRS_GO_RESET);
  // packed order: run, irq start, next start, pc load, pc
  assign CPU_O = srrs_pkg::srrs_cpu_t'({cpu_run, start_irq_q, start_next_q, pc_load_q, pc_q});

  // every register except the supply clear status holds its reset image throughout
  always_comb begin
    REGS_O.settle_time_select = `SRRS_RST_SETTLE_SEL;
    REGS_O.processor_status_word = `SRRS_RST_PSW;
    REGS_O.processor_clock_ctrl = `SRRS_RST_PCC;
    REGS_O.interrupt_request_reg0 = `SRRS_RST_IRQ_REQ;
    REGS_O.interrupt_mask_reg0 = `SRRS_RST_IRQ_MASK;
    REGS_O.port_latch = `SRRS_RST_PORT_LATCH;
    REGS_O.port_direction = `SRRS_RST_PORT_DIR;
    REGS_O.port8_direction_reg = `SRRS_RST_PORT8_DIR;
    REGS_O.supply_clear_status_reg = supply_seen_q ? `SRRS_RST_SUPPLY_CLR_SET
                                                   : `SRRS_RST_SUPPLY_CLR_CLR;
  end

  // ==========================================================
  // checks
  property p_reset_hiz;
    @(posedge CLOCK_I) disable iff (RST_I)
      any_reset |-> PINS_HIZ_O;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven in reset");

  property p_settle_hiz;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_SETTLE) |-> PINS_HIZ_O && !CPU_O.cpu_run;
  endproperty
  a_settle_hiz: assert property (p_settle_hiz) else $error("active during settle");

  property p_reset_enter;
    @(posedge CLOCK_I) disable iff (RST_I)
      any_reset |=> (state_q == srrs_pkg::SRRS_RESET);
  endproperty
  a_reset_enter: assert property (p_reset_enter) else $error("reset not taken");

  property p_release;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_RESET && !any_reset) |=> (state_q == srrs_pkg::SRRS_SETTLE);
  endproperty
  a_release: assert property (p_release) else $error("release stuck");

  property p_masked_stays;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_STOP && !wake_irq && !any_reset) |=>
        (state_q == srrs_pkg::SRRS_STOP);
  endproperty
  a_masked_stays: assert property (p_masked_stays) else $error("stop left while masked");

  property p_wake;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_STOP && wake_irq && !any_reset) |=>
        (state_q == srrs_pkg::SRRS_WAKE);
  endproperty
  a_wake: assert property (p_wake) else $error("stop not released");

  property p_irq_after_settle;
    @(posedge CLOCK_I) disable iff (RST_I)
      CPU_O.start_irq |-> $past(state_q) == srrs_pkg::SRRS_WAKE && $past(settle_done);
  endproperty
  a_irq_after_settle: assert property (p_irq_after_settle) else $error("early irq");

  property p_status;
    @(posedge CLOCK_I) disable iff (RST_I)
      SUPPLY_LOW_I |=> REGS_O.supply_clear_status_reg == 8'h04;
  endproperty
  a_status: assert property (p_status) else $error("supply status wrong");

  property p_regs;
    @(posedge CLOCK_I) disable iff (RST_I)
      in_reset_seq |-> REGS_O.interrupt_mask_reg0 == 8'hFF && REGS_O.port8_direction_reg == 8'h3F;
  endproperty
  a_regs: assert property (p_regs) else $error("reset image wrong");

  property p_pc_loaded;
    @(posedge CLOCK_I) disable iff (RST_I)
      CPU_O.pc_load |-> (CPU_O.pc == RESET_VECTOR);
  endproperty
  a_pc_loaded: assert property (p_pc_loaded) else $error("pc not from vector");

  property p_pc_load_once;
    @(posedge CLOCK_I) disable iff (RST_I)
      CPU_O.pc_load |=> !CPU_O.pc_load;
  endproperty
  a_pc_load_once: assert property (p_pc_load_once) else $error("pc load repeated");

  property p_settle_wait;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_SETTLE && !settle_done && !any_reset) |=> (state_q == srrs_pkg::SRRS_SETTLE);
  endproperty
  a_settle_wait: assert property (p_settle_wait) else $error("settle cut short");

  property p_wake_wait;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_WAKE && !settle_done && !any_reset) |=> (state_q == srrs_pkg::SRRS_WAKE);
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake wait cut short");

  property p_next_after_settle;
    @(posedge CLOCK_I) disable iff (RST_I)
      CPU_O.start_next |-> $past(state_q) == srrs_pkg::SRRS_WAKE && $past(settle_done) &&
        $past(after_q) == srrs_pkg::SRRS_GO_NEXT;
  endproperty
  a_next_after_settle: assert property (p_next_after_settle) else $error("early next");

  property p_stop_osc;
    @(posedge CLOCK_I) disable iff (RST_I)
      STOPPED_O |-> !OSC_RUN_O;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator runs in stop");

  property p_ram_hold;
    @(posedge CLOCK_I) disable iff (RST_I)
      (state_q == srrs_pkg::SRRS_STOP) |=> RAM_HOLD_O;
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("ram not held");
endmodule
`default_nettype wire

// ===== hdl/srrs_map.svh
// srrs_map.svh: offsets-free constants for the stop release and reset sequencer
// assumes: included by the top and settle counter files by bare name
`ifndef SRRS_MAP_SVH
`define SRRS_MAP_SVH

// ==========================================================
// settle wait exponents
`define SRRS_SETTLE_EXP_SHORT 15
`define SRRS_SETTLE_EXP_LONG 17
`define SRRS_SETTLE_BITS 18

// ==========================================================
// reset vector locations
`define SRRS_VEC_LO_ADDR 16'h0000
`define SRRS_VEC_HI_ADDR 16'h0001

// ==========================================================
// post-reset register values
`define SRRS_RST_SETTLE_SEL 8'h04
`define SRRS_RST_PSW 8'h02
`define SRRS_RST_PCC 8'h02
`define SRRS_RST_IRQ_REQ 8'h00
`define SRRS_RST_IRQ_MASK 8'hFF
`define SRRS_RST_PORT_LATCH 8'h00
`define SRRS_RST_PORT_DIR 8'hFF
`define SRRS_RST_PORT8_DIR 8'h3F
`define SRRS_RST_SUPPLY_CLR_SET 8'h04
`define SRRS_RST_SUPPLY_CLR_CLR 8'h00

// ==========================================================
// external reset pin minimum low time
`define SRRS_EXT_RST_MIN_NS 10000
`define SRRS_CLK_PERIOD_NS 5
`define SRRS_EXT_RST_MIN_CYC ((`SRRS_EXT_RST_MIN_NS + `SRRS_CLK_PERIOD_NS - 1) / `SRRS_CLK_PERIOD_NS)

`endif

// ===== hdl/srrs_pkg.sv
// srrs_pkg.sv: types of the stop release and reset sequencer
// assumes: nothing beyond the map header
`default_nettype none
package srrs_pkg;
  // gray codes along reset -> settle -> vec -> run -> stop -> wake
  typedef enum logic [2:0] {
    SRRS_RESET = 3'h0,
    SRRS_SETTLE = 3'h1,
    SRRS_VEC_LO = 3'h3,
    SRRS_VEC_HI = 3'h2,
    SRRS_RUN = 3'h6,
    SRRS_STOP = 3'h7,
    SRRS_WAKE = 3'h5
  } srrs_state_t;

  typedef enum logic [1:0] {
    SRRS_GO_RESET = 2'h0,
    SRRS_GO_NEXT = 2'h1,
    SRRS_GO_IRQ = 2'h2
  } srrs_after_t;

  // defined post-reset register image
  typedef struct packed {
    logic [7:0] settle_time_select;
    logic [7:0] processor_status_word;
    logic [7:0] processor_clock_ctrl;
    logic [7:0] interrupt_request_reg0;
    logic [7:0] interrupt_mask_reg0;
    logic [7:0] port_latch;
    logic [7:0] port_direction;
    logic [7:0] port8_direction_reg;
    logic [7:0] supply_clear_status_reg;
  } srrs_regs_t;

  // cpu-facing controls
  typedef struct packed {
    logic cpu_run;
    logic start_irq;
    logic start_next;
    logic pc_load;
    logic [15:0] pc;
  } srrs_cpu_t;
endpackage
`default_nettype wire

// ===== hdl/srrs_settle_cnt.sv
// srrs_settle_cnt.sv: oscillator settling counter of main clock cycles
// assumes: start pulses once when the oscillator restarts
`include "srrs_map.svh"
`default_nettype none
module srrs_settle_cnt #(
  parameter int unsigned BITS = `SRRS_SETTLE_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic long_i,
  // status
  output logic busy_o,
  output logic done_o
);
  logic [BITS-1:0] cnt_q;
  logic [BITS-1:0] cnt_d;
  logic [BITS-1:0] term;
  logic busy_q;
  logic busy_d;
  logic hit;

  // terminal count is 2^exp - 1 so the wait spans exactly 2^exp cycles
  assign term = long_i ? BITS'((1 << `SRRS_SETTLE_EXP_LONG) - 1)
                       : BITS'((1 << `SRRS_SETTLE_EXP_SHORT) - 1);
  assign hit = busy_q && (cnt_q == term);
  assign busy_d = start_i ? 1'b1 : (hit ? 1'b0 : busy_q);
  assign cnt_d = start_i ? '0 : (busy_q ? cnt_q + BITS'(1) : cnt_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = hit && !start_i;

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
      (busy_q && !hit && !start_i) |=> (cnt_q == $past(cnt_q) + BITS'(1));
  endproperty
  a_count_step: assert property (p_count_step) else $error("settle count skipped");
endmodule
`default_nettype wire

// ===== hdl/srrs_vec_rom.sv
// srrs_vec_rom.sv: two-byte reset vector store with registered read
// assumes: contents fixed at build, addressed by the low address bit
`default_nettype none
module srrs_vec_rom #(
  parameter logic [15:0] VECTOR = 16'h0100
) (
  // clock
  input wire logic clk_i,
  // read port
  input wire logic addr_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:1];
  assign mem[0] = VECTOR[7:0];
  assign mem[1] = VECTOR[15:8];

  always_ff @(posedge clk_i) begin
    data_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// ===== tb/srrs_src_model.sv
// srrs_src_model.sv: reset sources that stand outside the sequencer
// assumes: clk_i is the sequencer clock; the bench calls the tasks
`default_nettype none
module srrs_src_model #(
  parameter int MIN_LOW_CYC = 2000
) (
  // clock
  input wire logic clk_i,
  // reset sources
  output logic reset_n_o,
  output logic wdt_ovf_o,
  output logic supply_low_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // power comes up with the supply still below threshold
  initial begin
    reset_n_o = 1'b1;
    wdt_ovf_o = 1'b0;
    supply_low_o = 1'b1;
  end

  // ==========================================================
  // drivers
  // pin held low past the minimum, since the design does not filter it
  task automatic pin_pulse(input int extra);
    @(posedge clk_i);
    #1 reset_n_o = 1'b0;
    repeat (MIN_LOW_CYC + extra) @(posedge clk_i);
    #1 reset_n_o = 1'b1;
  endtask

  task automatic wdt_pulse(input int cyc);
    @(posedge clk_i);
    #1 wdt_ovf_o = 1'b1;
    repeat (cyc) @(posedge clk_i);
    #1 wdt_ovf_o = 1'b0;
  endtask

  task automatic supply_set(input logic low);
    @(posedge clk_i);
    #1 supply_low_o = low;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top.sv: self-checking bench of the stop release and reset sequencer
// assumes: srrs_pkg and the design files are compiled before this file
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus and observed signals
  localparam int SETTLE = 1 << 15;
  localparam logic [15:0] VEC = 16'hA5C3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop_req = 1'b0;
  logic irq = 1'b0;
  logic mask = 1'b1;
  logic accept = 1'b0;
  wire logic reset_n;
  wire logic wdt_ovf;
  wire logic supply_low;
  srrs_pkg::srrs_cpu_t cpu;
  srrs_pkg::srrs_regs_t regs;
  logic osc_run;
  logic halt;
  logic stopped;
  logic pins_hiz;
  logic ram_hold;
  logic [15:0] lfsr = 16'h23A8;
  int fails = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  srrs_top #(.RESET_VECTOR(VEC)) i_dut (
    .CLOCK_I(clk), .RST_I(rst), .RESET_N_I(reset_n), .WDT_OVF_I(wdt_ovf),
    .SUPPLY_LOW_I(supply_low), .STOP_REQ_I(stop_req), .IRQ_PENDING_I(irq),
    .INTERRUPT_MASK_FLAG_I(mask), .INTERRUPT_ACCEPT_FLAG_I(accept),
    .CPU_O(cpu), .OSC_RUN_O(osc_run), .HALT_O(halt), .STOPPED_O(stopped),
    .PINS_HIZ_O(pins_hiz), .RAM_HOLD_O(ram_hold), .REGS_O(regs)
  );

  srrs_src_model i_src (
    .clk_i(clk), .reset_n_o(reset_n), .wdt_ovf_o(wdt_ovf), .supply_low_o(supply_low)
  );

  // ==========================================================
  // expectations and comparisons
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic srrs_pkg::srrs_regs_t exp_regs(input bit supply_rise_clear);
    srrs_pkg::srrs_regs_t r;
    r.settle_time_select = 8'h04;
    r.processor_status_word = 8'h02;
    r.processor_clock_ctrl = 8'h02;
    r.interrupt_request_reg0 = 8'h00;
    r.interrupt_mask_reg0 = 8'hFF;
    r.port_latch = 8'h00;
    r.port_direction = 8'hFF;
    r.port8_direction_reg = 8'h3F;
    r.supply_clear_status_reg = supply_rise_clear ? 8'h04 : 8'h00;
    return r;
  endfunction

  task automatic cmp_flag(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic cmp_word(input string what, input logic [71:0] exp, input logic [71:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // kind 0 pc load, 1 irq start, 2 next start; only the early part is
  // checked so the last few cycles of sequencing stay the design's own
  task automatic wait_pulse(input int kind, input logic hiz, output int n);
    bit hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < SETTLE + 100) begin
      @(posedge clk);
      #1 n++;
      hit = (kind == 0) ? (cpu.pc_load === 1'b1) :
            (kind == 1) ? (cpu.start_irq === 1'b1) : (cpu.start_next === 1'b1);
      if (!hit && n < SETTLE) begin
        cmp_flag("pins_hiz", hiz, pins_hiz);
        cmp_flag("cpu_run", 1'b0, cpu.cpu_run);
        cmp_flag("halt", kind != 0, halt);
      end
    end
  endtask

  task automatic stop_enter();
    @(posedge clk);
    #1 stop_req = 1'b1;
    @(posedge clk);
    #1 stop_req = 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp_flag("stopped", 1'b1, stopped);
    cmp_flag("osc_run", 1'b0, osc_run);
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    int n;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 cmp_flag("pins_hiz", 1'b1, pins_hiz);
    cmp_word("regs", exp_regs(1'b1), regs);
    i_src.supply_set(1'b0);
    wait_pulse(0, 1'b1, n);
    cmp_flag("settle_len", 1'b1, n >= SETTLE && n <= SETTLE + 8);
    cmp_word("pc", 72'(VEC), 72'(cpu.pc));
    cmp_word("regs", exp_regs(1'b1), regs);
    $display("test supply_release done");
    stop_enter();
    // random masked requests must not wake
    repeat (40) begin
      lfsr = lfsr_next(lfsr);
      irq = lfsr[0];
      accept = lfsr[1];
      @(posedge clk);
      #1 cmp_flag("stopped", 1'b1, stopped);
      cmp_flag("start", 1'b0, cpu.start_irq | cpu.start_next);
    end
    irq = 1'b1;
    mask = 1'b0;
    accept = 1'b1;
    wait_pulse(1, 1'b0, n);
    cmp_flag("wake_len", 1'b1, n >= SETTLE && n <= SETTLE + 8);
    irq = 1'b0;
    mask = 1'b1;
    accept = 1'b0;
    $display("test stop_wake_irq done");
    stop_enter();
    fork
      i_src.pin_pulse(int'(lfsr[3:0]));
      begin
        repeat (4) @(posedge clk);
        #1 cmp_flag("pins_hiz", 1'b1, pins_hiz);
        cmp_word("regs", exp_regs(1'b0), regs);
        cmp_flag("ram_hold", 1'b1, ram_hold);
      end
    join
    wait_pulse(0, 1'b1, n);
    cmp_flag("settle_len", 1'b1, n >= SETTLE && n <= SETTLE + 8);
    cmp_word("pc", 72'(VEC), 72'(cpu.pc));
    $display("test stop_pin_reset done");
    // pending unmasked request at stop entry drops to the halt-like wait
    irq = 1'b1;
    mask = 1'b0;
    accept = 1'b0;
    @(posedge clk);
    #1 stop_req = 1'b1;
    @(posedge clk);
    #1 stop_req = 1'b0;
    repeat (8) begin
      cmp_flag("halt", 1'b1, halt);
      cmp_flag("stopped", 1'b0, stopped);
      cmp_flag("osc_run", 1'b1, osc_run);
      cmp_flag("pins_hiz", 1'b0, pins_hiz);
      @(posedge clk);
      #1;
    end
    irq = 1'b0;
    mask = 1'b1;
    $display("test stop_pending_next done");
    lfsr = lfsr_next(lfsr);
    i_src.wdt_pulse(1 + int'(lfsr[1:0]));
    // after the pulse the wait runs on by itself
    repeat (20) begin
      @(posedge clk);
      #1 cmp_flag("pins_hiz", 1'b1, pins_hiz);
      cmp_word("regs", exp_regs(1'b0), regs);
      cmp_flag("halt", 1'b0, halt);
    end
    $display("test watchdog_reset done");
    wrap_up();
  end

  // ==========================================================
  // hang guard: three settle waits plus the pin reset and margin
  initial begin
    #(5 * (3 * SETTLE + 6000));
    fails++;
    $display("timeout reached");
    wrap_up();
  end
endmodule
`default_nettype wire
